// [src/saud_pkg.sv]
// Package for the serial audio port: register map, field positions, reset values.
// Assumes a 32-bit APB bus with byte addresses and aligned word registers.
package saud_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_FIRST_CONFIG = 12'H000;
	localparam logic [11:0] OFF_FIFO_STATUS  = 12'H004;
	localparam logic [11:0] OFF_INT_MASK     = 12'H008;
	localparam logic [11:0] OFF_TX_DATA      = 12'H00C;
	localparam logic [11:0] OFF_RX_DATA      = 12'H010;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_DSP_BIT    = 1;
	localparam int CFG_ROLE_LSB   = 4;
	localparam int CFG_LEN_LSB    = 8;
	localparam int ST_UNDERRUN    = 0;
	localparam int ST_TX_EMPTY    = 1;
	localparam int ST_TX_FULL     = 2;
	localparam int ST_RX_EMPTY    = 3;
	localparam int ST_RX_FULL     = 4;
	localparam int MASK_UNDERRUN  = 0;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  ROLE_SLAVE     = 2'H0;
	localparam logic [1:0]  ROLE_WS_MASTER = 2'H1;
	localparam logic [1:0]  ROLE_RESET     = 2'H0;
	localparam logic [4:0]  LEN_RESET      = 5'H0F;
	localparam logic [31:0] READ_ZERO      = 32'H00000000;
	localparam int          FIFO_DEPTH     = 4;
	localparam int          SYNC_STAGES    = 3;

endpackage

// [src/saud_sync.sv]
// Three-stage input synchroniser for link pins; a new level counts once stages two and three agree.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ns
module saud_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] level
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] stable;
	} saud_sync_s;

	saud_sync_s st;
	saud_sync_s next_st;

	// Stage one feeds stage two only; the agreement check looks at stages two and three
	always_comb begin
		next_st        = st;
		next_st.ff1    = async;
		next_st.ff2    = st.ff1;
		next_st.ff3    = st.ff2;
		next_st.stable = ((st.ff2 ~^ st.ff3) & st.ff3) | ((st.ff2 ^ st.ff3) & st.stable);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.stable;

endmodule

// [src/saud_top.sv]
// Serial audio port: one channel pair between word FIFOs and a word-select framed audio link.
// Assumes APB access on clk, link bit clock and word select driven by an outside master.
// Overview of operation
// - An empty transmit FIFO at a word start sets the underrun flag and interrupts.
// - One left/right pair per instance; all samples pass through the instance FIFO.
// - Length field holds bits per sample minus one, for transmit and receive.
// - Every received bit is delivered, the most significant one included.
// - Word select marks each frame start; in standard mode its level selects left or right channel.
// - The bus master drives word select; slaves only receive it.
// - Role 0x1 is word-select synchronised master, 0x0 normal slave; both receive it.
// - After enable, transfers wait for a true frame start, never a second edge.
// - In standard mode a frame begins at the falling edge of word select.
// - In DSP mode a frame begins at the rising edge of word select.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
module saud_top (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        bitClk,
	input  wire logic        wordSel,
	input  wire logic        serDataIn,
	output logic             serDataOut
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             en;
		logic             dsp;
		logic [1:0]       role;
		logic [4:0]       len;
		logic             mask;
		logic             underrun;
		logic [3:0][31:0] txMem;
		logic [2:0]       txWr;
		logic [2:0]       txRd;
		logic [3:0][31:0] rxMem;
		logic [2:0]       rxWr;
		logic [2:0]       rxRd;
		logic             sckPrev;
		logic             wsPrev;
		logic             aligned;
		logic             inWord;
		logic             chan;
		logic [5:0]       cnt;
		logic [31:0]      txWord;
		logic [31:0]      rxShift;
		logic             msbCap;
		logic             sdOut;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             irq;
	} saud_state_s;

	saud_state_s st;
	saud_state_s next_st;

	logic [2:0] linkLevel;
	logic       sck;
	logic       ws;
	logic       sd;

	saud_sync #(
		.W(3)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.async({serDataIn, wordSel, bitClk}),
		.level(linkLevel)
	);

	assign sck = linkLevel[0];
	assign ws  = linkLevel[1];
	assign sd  = linkLevel[2];

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic fifoFull(input logic [2:0] wr, input logic [2:0] rd);
		fifoFull = (wr[2] != rd[2]) && (wr[1:0] == rd[1:0]);
	endfunction

	function automatic logic fifoEmpty(input logic [2:0] wr, input logic [2:0] rd);
		fifoEmpty = (wr == rd);
	endfunction

	// Reserved role codes leave the engine idle
	function automatic logic wsReceiver(input logic [1:0] role);
		wsReceiver = (role == saud_pkg::ROLE_SLAVE) || (role == saud_pkg::ROLE_WS_MASTER);
	endfunction

	logic        acc;
	logic        clrUnder;
	logic        rise;
	logic        fall;
	logic        wsFell;
	logic        wsRose;
	logic        frameStart;
	logic        lastBit;
	logic        dspRight;
	logic        wordStart;
	logic        rxPush;
	logic        txEmpty;
	logic        txFull;
	logic        rxEmpty;
	logic        rxFull;
	logic [31:0] rxPushWord;
	logic [4:0]  txIdx;

	always_comb begin
		acc      = psel && penable && !st.pready;
		clrUnder = acc && pwrite && (paddr == saud_pkg::OFF_FIFO_STATUS) && pwdata[saud_pkg::ST_UNDERRUN];
		txEmpty  = fifoEmpty(st.txWr, st.txRd);
		txFull   = fifoFull(st.txWr, st.txRd);
		rxEmpty  = fifoEmpty(st.rxWr, st.rxRd);
		rxFull   = fifoFull(st.rxWr, st.rxRd);
		rise     = sck && !st.sckPrev;
		fall     = !sck && st.sckPrev;
		wsFell   = rise && st.wsPrev && !ws;
		wsRose   = rise && !st.wsPrev && ws;
		frameStart = st.en && wsReceiver(st.role) && (st.dsp ? wsRose : wsFell);
		lastBit  = st.inWord && (st.cnt == {1'b0, st.len});
		dspRight = st.dsp && rise && lastBit && !st.chan && st.aligned;
		// Words only start once aligned; the first start is the frame edge itself
		wordStart = st.en && wsReceiver(st.role) && (st.aligned || frameStart)
			&& (st.dsp ? (frameStart || dspRight) : (wsFell || wsRose));
		rxPushWord = {st.rxShift[30:0], sd};
		rxPush   = rise && lastBit;
		txIdx    = st.len - st.cnt[4:0];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st         = st;
		next_st.pready  = acc;
		next_st.pslverr = 1'b0;
		next_st.prdata  = saud_pkg::READ_ZERO;
		next_st.sckPrev = sck;
		next_st.irq     = st.underrun && st.mask;

		// Register access takes effect on the first access cycle; pready follows one cycle later
		if (acc) begin
			case (paddr)
				saud_pkg::OFF_FIRST_CONFIG: begin
					if (pwrite) begin
						next_st.en   = pwdata[saud_pkg::CFG_ENABLE_BIT];
						next_st.dsp  = pwdata[saud_pkg::CFG_DSP_BIT];
						next_st.role = pwdata[saud_pkg::CFG_ROLE_LSB +: 2];
						next_st.len  = pwdata[saud_pkg::CFG_LEN_LSB +: 5];
					end else begin
						next_st.prdata[saud_pkg::CFG_ENABLE_BIT]     = st.en;
						next_st.prdata[saud_pkg::CFG_DSP_BIT]        = st.dsp;
						next_st.prdata[saud_pkg::CFG_ROLE_LSB +: 2]  = st.role;
						next_st.prdata[saud_pkg::CFG_LEN_LSB +: 5]   = st.len;
					end
				end
				saud_pkg::OFF_FIFO_STATUS: begin
					if (clrUnder) begin
						next_st.underrun = 1'b0;
					end
					next_st.prdata[saud_pkg::ST_UNDERRUN] = st.underrun;
					next_st.prdata[saud_pkg::ST_TX_EMPTY] = txEmpty;
					next_st.prdata[saud_pkg::ST_TX_FULL]  = txFull;
					next_st.prdata[saud_pkg::ST_RX_EMPTY] = rxEmpty;
					next_st.prdata[saud_pkg::ST_RX_FULL]  = rxFull;
				end
				saud_pkg::OFF_INT_MASK: begin
					if (pwrite) begin
						next_st.mask = pwdata[saud_pkg::MASK_UNDERRUN];
					end
					next_st.prdata[saud_pkg::MASK_UNDERRUN] = st.mask;
				end
				saud_pkg::OFF_TX_DATA: begin
					// A write to a full FIFO is dropped rather than stalling the bus
					if (pwrite && !txFull) begin
						next_st.txMem[st.txWr[1:0]] = pwdata;
						next_st.txWr = st.txWr + 3'H1;
					end
				end
				saud_pkg::OFF_RX_DATA: begin
					if (!pwrite && !rxEmpty) begin
						next_st.prdata = st.rxMem[st.rxRd[1:0]];
						next_st.rxRd   = st.rxRd + 3'H1;
					end
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// Link engine; alignment is lost whenever the block is disabled
		if (!st.en) begin
			next_st.aligned = 1'b0;
			next_st.inWord  = 1'b0;
			next_st.sdOut   = 1'b0;
		end else if (frameStart) begin
			next_st.aligned = 1'b1;
		end

		if (rise) begin
			next_st.wsPrev = ws;
			if (st.inWord && st.cnt <= {1'b0, st.len}) begin
				next_st.rxShift = rxPushWord;
				if (st.cnt == 6'H00) begin
					next_st.msbCap = sd;
				end
			end
			// Full receive FIFO drops the word; transmit side keeps running
			if (rxPush && !rxFull) begin
				next_st.rxMem[st.rxWr[1:0]] = rxPushWord;
				next_st.rxWr = st.rxWr + 3'H1;
			end
			if (wordStart) begin
				next_st.inWord  = 1'b1;
				next_st.cnt     = 6'H00;
				next_st.rxShift = 32'H00000000;
				next_st.chan    = st.dsp ? dspRight : ws;
				if (txEmpty) begin
					next_st.txWord   = 32'H00000000;
					next_st.underrun = 1'b1;
				end else begin
					next_st.txWord = st.txMem[st.txRd[1:0]];
					next_st.txRd   = st.txRd + 3'H1;
				end
			end else if (st.inWord && st.cnt <= {1'b0, st.len}) begin
				next_st.cnt = st.cnt + 6'H01;
			end
		end

		if (fall && st.en) begin
			next_st.sdOut = st.inWord && (st.cnt <= {1'b0, st.len}) && st.txWord[txIdx];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st      <= '0;
			st.role <= saud_pkg::ROLE_RESET;
			st.len  <= saud_pkg::LEN_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign prdata     = st.prdata;
	assign pready     = st.pready;
	assign pslverr    = st.pslverr;
	assign irq        = st.irq;
	assign serDataOut = st.sdOut;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence stdFrameEdge;
		st.en && !st.dsp && wsReceiver(st.role) && wsFell;
	endsequence

	sequence dspFrameEdge;
		st.en && st.dsp && wsReceiver(st.role) && wsRose;
	endsequence

	sequence wordOpened;
		st.inWord && (st.cnt == 6'H00) && !st.chan;
	endsequence

	underrun_set_a: assert property (@(posedge clk) disable iff (!nrst)
		rise && wordStart && txEmpty |=> st.underrun)
		else $error("underrun flag not set on empty transmit FIFO");

	underrun_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		st.underrun && !clrUnder |=> st.underrun)
		else $error("underrun flag dropped without a clear");

	irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
		st.underrun && st.mask |=> irq)
		else $error("interrupt low while unmasked underrun set");

	irq_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		!st.underrun |=> !irq)
		else $error("interrupt high without underrun");

	length_push_a: assert property (@(posedge clk) disable iff (!nrst)
		rxPush && !rxFull |=> st.rxWr == 3'($past(st.rxWr) + 3'H1))
		else $error("received word not stored after last bit");

	std_frame_a: assert property (@(posedge clk) disable iff (!nrst)
		stdFrameEdge |=> wordOpened)
		else $error("standard frame not opened at falling word select");

	dsp_frame_a: assert property (@(posedge clk) disable iff (!nrst)
		dspFrameEdge |=> wordOpened)
		else $error("DSP frame not opened at rising word select");

	align_wait_a: assert property (@(posedge clk) disable iff (!nrst)
		st.en && !st.aligned && !frameStart |-> !wordStart ##1 !st.aligned)
		else $error("transfer started before a true frame start");

	msb_keep_a: assert property (@(posedge clk) disable iff (!nrst)
		rxPush && (st.len != 5'H00) |-> rxPushWord[st.len] == st.msbCap)
		else $error("received most significant bit lost");

endmodule

// [bench/saud_link_master.sv]
// Audio link master model: makes bit clock, word select and receive data, captures transmit data.
// Assumes the block is a word-select slave; the bit clock stands low between frames.
`timescale 1ns/1ns
module saud_link_master (
	output logic      bitClk,
	output logic      wordSel,
	output logic      serDataIn,
	input  wire logic serDataOut
);
	initial begin
		bitClk = 1'b0;
		wordSel = 1'b1;
		serDataIn = 1'b0;
	end

	// --------------------------------------------------------------
	// One frame of two words
	// --------------------------------------------------------------
	// A lead slot settles the idle word-select level, so a stale sample never fakes an edge
	task automatic frame(input int len, input bit dsp, input logic [31:0] rxL, rxR,
		output logic [31:0] gotL, gotR);
		int k;
		int n;
		n = len + 1;
		gotL = 32'H0;
		gotR = 32'H0;
		#7;
		for (int t = 0; t <= 2 * n + 2; t++) begin
			k = t - 3;
			if (k >= 0 && k < n) gotL = {gotL[30:0], serDataOut};
			else if (k >= n && k < 2 * n) gotR = {gotR[30:0], serDataOut};
			bitClk = 1'b0;
			if (t == 2 * n + 2) break;
			k = t - 2;
			wordSel = (t == 0) ? !dsp : (dsp ? (t == 1) : (t > n));
			// Outside the words the line toggles so a stale bit cannot pass for data
			if (k >= 0 && k < n) serDataIn = rxL[len - k];
			else if (k >= n && k < 2 * n) serDataIn = rxR[len - k + n];
			else serDataIn = ~serDataIn;
			#80;
			bitClk = 1'b1;
			#80;
		end
	endtask
endmodule

// [bench/serial_audio_port_test.sv]
// Self-checking bench for the serial audio port: row table of transfers, then hand-written cases.
// Assumes saud_top, saud_pkg and the link master model are compiled first.
`timescale 1ns/1ns
module serial_audio_port_test;
	typedef struct {bit dsp; logic [1:0] role; int len; logic [31:0] txL, txR, rxL, rxR;} saud_row_s;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq, lastErr;
	logic        bitClk, wordSel, serDataIn, serDataOut;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, gotL, gotR, m;
	int          badCount = 0;
	int          numChecks = 0;
	saud_row_s   r;
	saud_row_s   rows [6] = '{
		'{0, 2'H0, 15, 32'H0000A5C3, 32'H00005A3C, 32'H0000F00F, 32'H00008001},
		'{0, 2'H1, 23, 32'H00C0FFEE, 32'H00813579, 32'H00FEDCBA, 32'H00800001},
		'{0, 2'H0, 24, 32'H01ABCDEF, 32'H00F0F0F0, 32'H01000001, 32'H01FFFFFF},
		'{1, 2'H1, 31, 32'H89ABCDEF, 32'H12345678, 32'H80000000, 32'HFEDCBA98},
		'{1, 2'H0, 7, 32'H000000C3, 32'H0000013C, 32'H00000081, 32'H0000017E},
		'{0, 2'H1, 31, 32'HF0E1D2C3, 32'H0F1E2D3C, 32'HC0000003, 32'H80000001}};

	saud_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .bitClk(bitClk),
		.wordSel(wordSel), .serDataIn(serDataIn), .serDataOut(serDataOut));
	saud_link_master link_u (.bitClk(bitClk), .wordSel(wordSel), .serDataIn(serDataIn), .serDataOut(serDataOut));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		numChecks++;
		if (got !== exp) begin
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
			badCount++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// The answer is registered: its level at the falling edge is what the next rising edge sees
		do @(negedge clk); while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'H0);
		chk(q, exp);
	endtask

	function automatic logic [31:0] cfgWord(int len, logic [1:0] role, logic dsp, logic en);
		return {19'H0, len[4:0], 2'H0, role, 2'H0, dsp, en};
	endfunction

	task automatic testDone;
		if (badCount == 0 && numChecks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Clock, watchdog and tests
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Ten frames come to some 400 bit clocks, about 64 us; the limit leaves ample margin for bus traffic
	initial begin
		#400000;
		badCount++;
		testDone;
	end

	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rdChk(saud_pkg::OFF_FIRST_CONFIG, 32'H00000F00);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H0000000A);
		rdChk(saud_pkg::OFF_TX_DATA, saud_pkg::READ_ZERO);
		apb(1'b0, 12'H020, 32'H0);
		chk({31'H0, lastErr}, 32'H1);
		foreach (rows[i]) begin
			r = rows[i];
			m = 32'HFFFFFFFF >> (31 - r.len);
			apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(r.len, r.role, r.dsp, 1'b0));
			apb(1'b1, saud_pkg::OFF_TX_DATA, r.txL);
			apb(1'b1, saud_pkg::OFF_TX_DATA, r.txR);
			apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(r.len, r.role, r.dsp, 1'b1));
			link_u.frame(r.len, r.dsp, r.rxL, r.rxR, gotL, gotR);
			chk(gotL, r.txL & m);
			chk(gotR, r.txR & m);
			rdChk(saud_pkg::OFF_RX_DATA, r.rxL & m);
			rdChk(saud_pkg::OFF_RX_DATA, r.rxR & m);
			rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H0000000A);
		end
		// Enabled mid-word on a running bus: the right-word edge must not align the block
		apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(15, 2'H0, 1'b0, 1'b0));
		apb(1'b1, saud_pkg::OFF_TX_DATA, 32'H00001357);
		apb(1'b1, saud_pkg::OFF_TX_DATA, 32'H00002468);
		fork
			link_u.frame(15, 1'b0, 32'H1111, 32'H2222, gotL, gotR);
			begin
				repeat (6) @(posedge bitClk);
				apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(15, 2'H0, 1'b0, 1'b1));
			end
		join
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H00000008);
		link_u.frame(15, 1'b0, 32'H0000ABCD, 32'H00004321, gotL, gotR);
		chk(gotL, 32'H00001357);
		chk(gotR, 32'H00002468);
		rdChk(saud_pkg::OFF_RX_DATA, 32'H0000ABCD);
		rdChk(saud_pkg::OFF_RX_DATA, 32'H00004321);
		// Empty transmit queue during a frame, then mask and clear the flag
		apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(7, 2'H1, 1'b0, 1'b0));
		apb(1'b1, saud_pkg::OFF_INT_MASK, 32'H1);
		apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(7, 2'H1, 1'b0, 1'b1));
		link_u.frame(7, 1'b0, 32'HA5, 32'H3C, gotL, gotR);
		chk(gotL | gotR, 32'H0);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H00000003);
		repeat (50) @(posedge clk);
		chk({31'H0, irq}, 32'H1);
		apb(1'b1, saud_pkg::OFF_INT_MASK, 32'H0);
		repeat (2) @(posedge clk);
		chk({31'H0, irq}, 32'H0);
		apb(1'b1, saud_pkg::OFF_INT_MASK, 32'H1);
		repeat (2) @(posedge clk);
		chk({31'H0, irq}, 32'H1);
		apb(1'b1, saud_pkg::OFF_FIFO_STATUS, 32'H1);
		repeat (2) @(posedge clk);
		chk({31'H0, irq}, 32'H0);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H00000002);
		// Fill the transmit queue, the fifth word being dropped, then run a frame under a reserved role
		for (int i = 1; i <= 5; i++) apb(1'b1, saud_pkg::OFF_TX_DATA, 32'H00000011 * i);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H00000004);
		apb(1'b1, saud_pkg::OFF_FIRST_CONFIG, cfgWord(7, 2'H2, 1'b0, 1'b1));
		link_u.frame(7, 1'b0, 32'H5A, 32'HC3, gotL, gotR);
		chk(gotL | gotR, 32'H0);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H00000004);
		rdChk(saud_pkg::OFF_RX_DATA, 32'H000000A5);
		rdChk(saud_pkg::OFF_RX_DATA, 32'H0000003C);
		rdChk(saud_pkg::OFF_RX_DATA, saud_pkg::READ_ZERO);
		// Reset in mid-run returns every register to its reset value
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		chk({30'H0, irq, serDataOut}, 32'H0);
		nrst <= 1'b1;
		rdChk(saud_pkg::OFF_FIRST_CONFIG, 32'H00000F00);
		rdChk(saud_pkg::OFF_FIFO_STATUS, 32'H0000000A);
		testDone;
	end
endmodule
